// ===== src/pmr_pkg.sv
/*
  Constants, field layouts and state types for the MAC-facing receive pins
  and configuration straps of a 10/100 transceiver.
  Assumes one 40 MHz clock for the whole block.
*/
package pmr_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int RXCLK_HALF_10_NS = 200;
  localparam int RXCLK_HALF_100_NS = 20;
  localparam int HALF_10_CYC = (RXCLK_HALF_10_NS / CLK_PERIOD_NS < 1) ? 1 : RXCLK_HALF_10_NS / CLK_PERIOD_NS;
  localparam int HALF_100_CYC = (RXCLK_HALF_100_NS / CLK_PERIOD_NS < 1) ? 1 : RXCLK_HALF_100_NS / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_10_RELOAD = 4'(HALF_10_CYC - 1);
  localparam logic [3:0] HALF_100_RELOAD = 4'(HALF_100_CYC - 1);

  // Register byte addresses
  localparam logic [3:0] ADDR_WAKE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // Control word fields
  localparam int CTL_INDICATOR_ONE_LSB = 0;
  localparam int CTL_INDICATOR_TWO_LSB = 2;
  localparam int CTL_EEE = 4;
  localparam int CTL_SYM = 5;
  localparam int CTL_SPD100 = 6;
  localparam int CTL_FDX = 7;
  localparam int CTL_PME_RXD2 = 8;
  localparam logic [1:0] INDICATOR_ONE_SEL_RESET = 2'h0;
  localparam logic [1:0] INDICATOR_TWO_SEL_RESET = 2'h1;

  // Strap vector positions
  localparam int STRAP_MODE0 = 0;
  localparam int STRAP_MODE1 = 1;
  localparam int STRAP_MODE2 = 2;
  localparam int STRAP_AD0 = 3;
  localparam int STRAP_AD2 = 4;
  localparam int STRAP_AD1 = 5;
  localparam int STRAP_RMII = 6;
  localparam int STRAP_CORE_REGULATOR_DISABLE = 7;
  localparam int STRAP_IRQSEL = 8;
  localparam int STRAP_W = 9;
  localparam int CFG_SPD100 = 0;
  localparam int CFG_FDX = 1;

  localparam logic [7:0] SFD_PATTERN = 8'hAB;

  typedef enum logic [1:0] {
    LED_ACTIVITY,
    LED_SPEED,
    LED_IRQ,
    LED_PME
  } pmr_led_e;

  typedef enum logic [1:0] {
    PH_SETTLE,
    PH_FILL,
    PH_SAMPLE,
    PH_RUN
  } pmr_phase_e;

endpackage

// ===== src/pmr_rx_pins.sv
/*
  Receive-side MAC pins, shared strap pins, indicators, interrupt pin and
  management pin buffering, plus an Avalon-MM register slave.
  Assumes the PHY core supplies decoded receive signals on clk_in; the
  strap, management and transmit-error pins arrive asynchronously.
*/
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module pmr_rx_pins
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] rx_data_in,
  input wire logic rx_sym_msb_in,
  input wire logic rx_dv_in,
  input wire logic rx_err_in,
  input wire logic rx_lpi_in,
  input wire logic crs_in,
  input wire logic col_in,
  input wire logic tx_en_in,
  input wire logic link_up_in,
  input wire logic link_act_in,
  input wire logic irq_in,
  input wire logic pme_in,
  input wire logic mdio_drive_in,
  input wire logic mdio_data_in,
  input wire logic [3:0] rxd_pin_in,
  output logic [3:0] rxd_pin_out,
  output logic [3:0] rxd_pin_oe_out,
  input wire logic rxer_pin_in,
  output logic rxer_pin_out,
  output logic rxer_pin_oe_out,
  input wire logic rxclk_pin_in,
  output logic rxclk_pin_out,
  output logic rxclk_pin_oe_out,
  output logic rxdv_pin_out,
  input wire logic col_pin_in,
  output logic col_pin_out,
  output logic col_pin_oe_out,
  output logic crs_pin_out,
  input wire logic indicator_one_in,
  output logic indicator_one_out,
  output logic indicator_one_oe_out,
  input wire logic indicator_two_in,
  output logic indicator_two_out,
  output logic indicator_two_oe_out,
  input wire logic irq_pin_in,
  output logic irq_pin_out,
  output logic irq_pin_oe_out,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  output logic [2:0] phy_config_straps_out,
  output logic [2:0] mgmt_addr_straps_out,
  output logic reduced_iface_select_out,
  output logic irq_pin_function_select_out,
  output logic regulator_enable_out,
  output logic straps_valid_out,
  output logic tx_err_out,
  output logic mdc_rise_out,
  output logic mdio_sample_out,
  output logic rx_strobe_out
);
  import pmr_pkg::*;

  typedef struct packed {
    pmr_phase_e phase;
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic [2:0] cfg;
    logic [2:0] addr;
    logic rmii;
    logic irqsel;
    logic reg_en;
    pmr_led_e indicator_one_sel;
    pmr_led_e indicator_two_sel;
    logic eee_en;
    logic sym_mode;
    logic spd100;
    logic fdx;
    logic pme_rxd2;
    logic [3:0] div_cnt;
    logic rxclk;
    logic rx_strobe;
    logic sfd_seen;
    logic [7:0] sfd_sr;
    logic [3:0] rxd;
    logic [3:0] rxd_oe;
    logic rxclk_oe, txer;
    logic rxer;
    logic rxdv;
    logic col;
    logic crs;
    logic drv_en;
    logic indicator_one;
    logic indicator_two;
    logic irq_pin;
    logic irq_oe;
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    logic [1:0] txer_s;
    logic mdc_rise;
    logic mdio_o;
    logic mdio_oe;
    logic waitreq;
    logic [31:0] rdata;
  } pmr_state_s;

  pmr_state_s st;
  pmr_state_s next_st;
  logic [STRAP_W-1:0] strap_raw;
  logic fall_tick;
  logic rmii10;
  logic [3:0] rx_word;
  logic [7:0] shifted_sr;
  logic irq_n;
  logic pme_n;

  assign strap_raw = {indicator_two_in, indicator_one_in, rxd_pin_in[2], rxclk_pin_in, rxd_pin_in[3],
                      rxer_pin_in, col_pin_in, rxd_pin_in[1], rxd_pin_in[0]};
  assign irq_n = ~irq_in;
  assign pme_n = ~pme_in;

  function automatic logic led_value(input pmr_led_e sel, input logic act, input logic spd,
                                     input logic irqn, input logic pmen);
    case (sel)
      LED_ACTIVITY: led_value = act;
      LED_SPEED: led_value = spd;
      LED_IRQ: led_value = irqn;
      default: led_value = pmen;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    fall_tick = (st.div_cnt == 4'h0) && st.rxclk;
    rmii10 = st.rmii && !st.spd100;
    rx_word = 4'h0;
    shifted_sr = {st.sfd_sr[5:0], rx_data_in[0], rx_data_in[1]};

    // Second stage is the only reader of each first stage
    next_st.strap_s1 = strap_raw;
    next_st.strap_s2 = st.strap_s1;
    next_st.mdc_s = {st.mdc_s[1:0], mdc_in};
    next_st.mdio_s = {st.mdio_s[0], mdio_in};
    next_st.txer_s = {st.txer_s[0], irq_pin_in};
    next_st.mdc_rise = st.mdc_s[1] && !st.mdc_s[2];
    next_st.txer = st.txer_s[1] && !st.irqsel;

    // Straps: two cycles to fill the synchroniser, then latch once per reset
    case (st.phase)
      PH_SETTLE: next_st.phase = PH_FILL;
      PH_FILL: next_st.phase = PH_SAMPLE;
      PH_SAMPLE:
      begin
        next_st.phase = PH_RUN;
        next_st.cfg = {st.strap_s2[STRAP_MODE2], st.strap_s2[STRAP_MODE1], st.strap_s2[STRAP_MODE0]};
        next_st.addr = {st.strap_s2[STRAP_AD2], st.strap_s2[STRAP_AD1], st.strap_s2[STRAP_AD0]};
        next_st.rmii = st.strap_s2[STRAP_RMII];
        next_st.irqsel = st.strap_s2[STRAP_IRQSEL];
        next_st.reg_en = !st.strap_s2[STRAP_CORE_REGULATOR_DISABLE];
        next_st.spd100 = st.strap_s2[STRAP_MODE0 + CFG_SPD100];
        next_st.fdx = st.strap_s2[STRAP_MODE0 + CFG_FDX];
        next_st.drv_en = 1'b1;
      end
      PH_RUN: next_st.phase = PH_RUN;
      default: next_st.phase = PH_SETTLE;
    endcase

    // Receive clock divider; at 40 MHz the 100 Mb/s rate is the nearest reachable
    if (st.div_cnt == 4'h0)
    begin
      next_st.rxclk = !st.rxclk;
      next_st.div_cnt = st.spd100 ? HALF_100_RELOAD : HALF_10_RELOAD;
    end
    else
    begin
      next_st.div_cnt = st.div_cnt - 4'h1;
    end

    next_st.rx_strobe = fall_tick;
    // Receive pins change only at the falling receive clock edge
    if (fall_tick)
    begin
      if (st.rmii)
      begin
        rx_word = {2'b00, rx_data_in[1:0]};
        if (rmii10)
        begin
          if (!rx_dv_in)
          begin
            next_st.sfd_seen = 1'b0;
            next_st.sfd_sr = 8'h00;
          end
          else
          begin
            next_st.sfd_sr = shifted_sr;
            if (shifted_sr == SFD_PATTERN)
            begin
              next_st.sfd_seen = 1'b1;
            end
          end
          if (!st.sfd_seen || (!st.fdx && tx_en_in))
          begin
            rx_word = 4'h0;
          end
        end
        next_st.col = crs_in || rx_dv_in;
        next_st.crs = 1'b0;
      end
      else
      begin
        rx_word = rx_data_in;
        next_st.col = col_in;
        next_st.crs = crs_in;
      end
      next_st.rxd = rx_word;
      next_st.rxdv = rx_dv_in;
      if (st.sym_mode)
      begin
        next_st.rxer = rx_sym_msb_in;
      end
      else if (rx_dv_in)
      begin
        next_st.rxer = rx_err_in;
      end
      else
      begin
        next_st.rxer = st.eee_en && rx_lpi_in;
      end
      if (st.rmii && st.pme_rxd2)
      begin
        next_st.rxd[2] = pme_n;
      end
    end

    // Output drivers stay off until straps are latched
    next_st.rxd_oe = st.drv_en ? (st.rmii ? {1'b0, st.pme_rxd2, 2'b11} : 4'hF) : 4'h0;
    next_st.rxclk_oe = st.drv_en && !st.rmii;
    next_st.indicator_one = led_value(st.indicator_one_sel, link_act_in, st.spd100, irq_n, pme_n);
    next_st.indicator_two = led_value(st.indicator_two_sel, link_act_in, st.spd100, irq_n, pme_n);
    // Open-drain interrupt: only ever pulls low
    next_st.irq_pin = 1'b0;
    next_st.irq_oe = st.drv_en && st.irqsel && irq_in && (st.indicator_one_sel != LED_IRQ)
                     && (st.indicator_two_sel != LED_IRQ);
    next_st.mdio_o = mdio_data_in;
    next_st.mdio_oe = st.drv_en && mdio_drive_in;

    // Avalon slave: one wait cycle, answer on the next
    next_st.waitreq = !((avs_read_in || avs_write_in) && st.waitreq);
    if ((avs_read_in || avs_write_in) && st.waitreq)
    begin
      next_st.rdata = 32'h0;
      if (avs_write_in && (avs_address_in == ADDR_WAKE_CTRL))
      begin
        if (avs_byteenable_in[0])
        begin
          next_st.indicator_one_sel = pmr_led_e'(avs_writedata_in[CTL_INDICATOR_ONE_LSB +: 2]);
          next_st.indicator_two_sel = pmr_led_e'(avs_writedata_in[CTL_INDICATOR_TWO_LSB +: 2]);
          next_st.eee_en = avs_writedata_in[CTL_EEE];
          next_st.sym_mode = avs_writedata_in[CTL_SYM];
          next_st.spd100 = avs_writedata_in[CTL_SPD100];
          next_st.fdx = avs_writedata_in[CTL_FDX];
        end
        if (avs_byteenable_in[1])
        begin
          next_st.pme_rxd2 = avs_writedata_in[CTL_PME_RXD2];
        end
      end
      else if (avs_read_in && (avs_address_in == ADDR_WAKE_CTRL))
      begin
        next_st.rdata[CTL_INDICATOR_ONE_LSB +: 2] = st.indicator_one_sel;
        next_st.rdata[CTL_INDICATOR_TWO_LSB +: 2] = st.indicator_two_sel;
        next_st.rdata[CTL_EEE] = st.eee_en;
        next_st.rdata[CTL_SYM] = st.sym_mode;
        next_st.rdata[CTL_SPD100] = st.spd100;
        next_st.rdata[CTL_FDX] = st.fdx;
        next_st.rdata[CTL_PME_RXD2] = st.pme_rxd2;
      end
      else if (avs_read_in && (avs_address_in == ADDR_STATUS))
      begin
        next_st.rdata[12:0] = {link_up_in, rx_dv_in, crs_in, st.phase == PH_RUN, !st.reg_en, st.irqsel,
                               st.rmii, st.addr, st.cfg};
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st <= '0;
      st.phase <= PH_SETTLE;
      st.indicator_one_sel <= pmr_led_e'(INDICATOR_ONE_SEL_RESET);
      st.indicator_two_sel <= pmr_led_e'(INDICATOR_TWO_SEL_RESET);
      st.irqsel <= 1'b1;
      st.waitreq <= 1'b1;
      st.reg_en <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = st.waitreq;
  assign rxd_pin_out = st.rxd;
  assign rxd_pin_oe_out = st.rxd_oe;
  assign rxer_pin_out = st.rxer;
  assign rxer_pin_oe_out = st.drv_en;
  assign rxclk_pin_out = st.rxclk;
  assign rxclk_pin_oe_out = st.rxclk_oe;
  assign rxdv_pin_out = st.rxdv;
  assign col_pin_out = st.col;
  assign col_pin_oe_out = st.drv_en;
  assign crs_pin_out = st.crs;
  assign indicator_one_out = st.indicator_one;
  assign indicator_one_oe_out = st.drv_en;
  assign indicator_two_out = st.indicator_two;
  assign indicator_two_oe_out = st.drv_en;
  assign irq_pin_out = st.irq_pin;
  assign irq_pin_oe_out = st.irq_oe;
  assign mdio_out = st.mdio_o;
  assign mdio_oe_out = st.mdio_oe;
  assign phy_config_straps_out = st.cfg;
  assign mgmt_addr_straps_out = st.addr;
  assign reduced_iface_select_out = st.rmii;
  assign irq_pin_function_select_out = st.irqsel;
  assign regulator_enable_out = st.reg_en;
  assign straps_valid_out = st.drv_en;
  assign tx_err_out = st.txer;
  assign mdc_rise_out = st.mdc_rise;
  assign mdio_sample_out = st.mdio_s[1];
  assign rx_strobe_out = st.rx_strobe;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_drv_off_before_latch;
    (st.phase != PH_RUN) |-> (st.rxd_oe == 4'h0) && !st.drv_en;
  endproperty
  a_drv_off_before_latch: assert property (p_drv_off_before_latch) else $error("driver on before strap latch");

  property p_straps_held;
    (st.phase == PH_RUN) && ($past(st.phase) == PH_RUN) |-> $stable(st.cfg) && $stable(st.addr)
      && $stable(st.rmii) && $stable(st.irqsel) && $stable(st.reg_en);
  endproperty
  a_straps_held: assert property (p_straps_held) else $error("latched strap changed");

  property p_rxclk_10_high;
    $rose(st.rxclk) && !st.spd100 && $past(!st.spd100) |-> (st.rxclk || st.spd100)[*8] ##1 (!st.rxclk || st.spd100);
  endproperty
  a_rxclk_10_high: assert property (p_rxclk_10_high) else $error("10 Mb/s receive clock half period wrong");

  property p_lpi_on_rxer;
    fall_tick && !rx_dv_in && st.eee_en && !st.sym_mode |=> st.rxer == $past(rx_lpi_in) && !st.rxdv;
  endproperty
  a_lpi_on_rxer: assert property (p_lpi_on_rxer) else $error("low-power idle not shown on error pin");

  property p_rmii_sfd_hold;
    fall_tick && rmii10 && !st.sfd_seen |=> st.rxd[1:0] == 2'b00;
  endproperty
  a_rmii_sfd_hold: assert property (p_rmii_sfd_hold) else $error("data left low hold before delimiter");

  property p_crs_dv;
    fall_tick && st.rmii |=> st.col == $past(crs_in || rx_dv_in);
  endproperty
  a_crs_dv: assert property (p_crs_dv) else $error("carrier/valid output wrong");

  property p_indicator_one_irq;
    st.indicator_one_sel == LED_IRQ |=> st.indicator_one == !$past(irq_in);
  endproperty
  a_indicator_one_irq: assert property (p_indicator_one_irq) else $error("indicator one does not show interrupt");

  property p_irq_pin;
    st.drv_en && st.irqsel && irq_in && st.indicator_one_sel != LED_IRQ && st.indicator_two_sel != LED_IRQ |=> st.irq_oe;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not pulled low");

  property p_mii_data;
    fall_tick && !st.rmii |=> st.rxd == $past(rx_data_in) && st.crs == $past(crs_in);
  endproperty
  a_mii_data: assert property (p_mii_data) else $error("MII nibble not passed");

  property p_bus_answer;
    (avs_read_in || avs_write_in) && st.waitreq |=> !st.waitreq ##1 st.waitreq;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule // pmr_rx_pins

// ===== verification/pmr_mac_model.sv
/*
  Behavioural MAC-side partner: management clock source and receive sampler.
  Assumes receive pins are settled at the rising receive clock.
*/
`timescale 1ns/100ps
module pmr_mac_model
(
  input wire logic start_in,
  input wire logic rxclk_in,
  input wire logic [3:0] rxd_in,
  input wire logic rxdv_in,
  output logic mdc_out,
  output logic mdio_oe_out,
  output logic mdio_data_out,
  output logic [3:0] last_nibble_out,
  output logic [15:0] nibbles_out
);
  initial
  begin
    mdc_out = 1'b0;
    mdio_oe_out = 1'b0;
    mdio_data_out = 1'b0;
    last_nibble_out = 4'h0;
    nibbles_out = 16'h0;
  end

  // Clock stands still outside a frame; data toggles so a stale level is never seen
  always @(posedge start_in)
  begin
    mdio_oe_out = 1'b1;
    repeat (8)
    begin
      #100 mdc_out = 1'b1;
      #100 mdc_out = 1'b0;
      mdio_data_out = ~mdio_data_out;
    end
    mdio_oe_out = 1'b0;
  end

  always @(posedge rxclk_in)
  begin
    if (rxdv_in === 1'b1)
    begin
      last_nibble_out <= rxd_in;
      nibbles_out <= nibbles_out + 16'h1;
    end
  end
endmodule // pmr_mac_model

// ===== verification/pmr_rx_pins_tb_top.sv
/*
  Self-checking bench for the receive pins and straps block.
  Assumes the partner model above and the design's register map.
*/
`timescale 1ns/100ps
module pmr_rx_pins_tb_top;
  import pmr_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'h3, rx_data_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
  logic rx_sym_msb_in = 0, rx_dv_in = 0, rx_err_in = 0, rx_lpi_in = 0, crs_in = 0, col_in = 0, tx_en_in = 0;
  logic link_up_in = 0, link_act_in = 0, irq_in = 0, pme_in = 0, mdio_drive_in = 0, mdio_data_in = 0;
  logic [2:0] s_mode = 3'h0, s_addr = 3'h0, phy_config_straps_out, mgmt_addr_straps_out;
  logic s_rmii = 0, s_core_regulator_disable = 0, s_irqsel = 1, txer_drv = 0, start = 0, m_oe, m_data, mdc_in;
  logic avs_waitrequest_out, rxer_pin_out, rxer_pin_oe_out, rxclk_pin_out, rxclk_pin_oe_out, rxdv_pin_out;
  logic col_pin_out, col_pin_oe_out, crs_pin_out, indicator_one_out, indicator_one_oe_out;
  logic indicator_two_out, indicator_two_oe_out, irq_pin_out, irq_pin_oe_out, mdio_out, mdio_oe_out;
  logic reduced_iface_select_out, irq_pin_function_select_out, regulator_enable_out, straps_valid_out;
  logic tx_err_out, mdc_rise_out, mdio_sample_out, rx_strobe_out;
  logic [3:0] rxd_pin_out, rxd_pin_oe_out, last_nib;
  logic [15:0] nibs;
  wire [3:0] rxd_pin_in, strap4;
  wire rxer_pin_in, rxclk_pin_in, col_pin_in, indicator_one_in, indicator_two_in, irq_pin_in, mdio_in;
  int bad_count = 0, n_tests = 0, cycles = 0, rises = 0;

  // Each strap pin shows the device while driven, otherwise the strap resistor; irq and mdio pins fall back to the MAC drive or a pull-up
  assign strap4 = {s_addr[2], s_rmii, s_mode[1], s_mode[0]};
  assign rxd_pin_in = (rxd_pin_oe_out & rxd_pin_out) | (~rxd_pin_oe_out & strap4);
  assign rxer_pin_in = rxer_pin_oe_out ? rxer_pin_out : s_addr[0];
  assign rxclk_pin_in = rxclk_pin_oe_out ? rxclk_pin_out : s_addr[1];
  assign col_pin_in = col_pin_oe_out ? col_pin_out : s_mode[2];
  assign indicator_one_in = indicator_one_oe_out ? indicator_one_out : s_core_regulator_disable;
  assign indicator_two_in = indicator_two_oe_out ? indicator_two_out : s_irqsel;
  assign irq_pin_in = irq_pin_oe_out ? 1'b0 : (s_irqsel ? 1'b1 : txer_drv);
  assign mdio_in = mdio_oe_out ? mdio_out : (m_oe ? m_data : 1'b1);

  pmr_rx_pins pmr_rx_pins_inst (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .rx_data_in,
    .rx_sym_msb_in, .rx_dv_in, .rx_err_in, .rx_lpi_in, .crs_in, .col_in, .tx_en_in, .link_up_in,
    .link_act_in, .irq_in, .pme_in, .mdio_drive_in, .mdio_data_in, .rxd_pin_in, .rxd_pin_out,
    .rxd_pin_oe_out, .rxer_pin_in, .rxer_pin_out, .rxer_pin_oe_out, .rxclk_pin_in, .rxclk_pin_out,
    .rxclk_pin_oe_out, .rxdv_pin_out, .col_pin_in, .col_pin_out, .col_pin_oe_out, .crs_pin_out,
    .indicator_one_in, .indicator_one_out, .indicator_one_oe_out, .indicator_two_in, .indicator_two_out,
    .indicator_two_oe_out, .irq_pin_in, .irq_pin_out, .irq_pin_oe_out, .mdc_in, .mdio_in, .mdio_out,
    .mdio_oe_out, .phy_config_straps_out, .mgmt_addr_straps_out, .reduced_iface_select_out,
    .irq_pin_function_select_out, .regulator_enable_out, .straps_valid_out, .tx_err_out,
    .mdc_rise_out, .mdio_sample_out, .rx_strobe_out);

  pmr_mac_model pmr_mac_model_inst (.start_in(start), .rxclk_in(rxclk_pin_out), .rxd_in(rxd_pin_out),
    .rxdv_in(rxdv_pin_out), .mdc_out(mdc_in), .mdio_oe_out(m_oe), .mdio_data_out(m_data),
    .last_nibble_out(last_nib), .nibbles_out(nibs));

  always #12.5 clk_in = ~clk_in;

  always @(posedge clk_in)
  begin
    cycles++;
    if (mdc_rise_out === 1'b1)
      rises++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low, then lets one edge pass
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do
    begin
      @(posedge clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    r = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wt(input int n);
    repeat (n)
    begin
      do
      begin
        @(posedge clk_in);
      end
      while (rx_strobe_out !== 1'b1);
    end
  endtask

  task automatic wl(input logic v, inout int k);
    while (rxclk_pin_out !== v && k < 200)
    begin
      @(posedge clk_in);
      k++;
    end
  endtask

  task automatic do_reset(input logic [2:0] m, input logic [2:0] a, input logic rm, input logic rg,
                          input logic is);
    s_mode <= m;
    s_addr <= a;
    s_rmii <= rm;
    s_core_regulator_disable <= rg;
    s_irqsel <= is;
    rst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    check(32'({rxd_pin_oe_out, rxer_pin_oe_out, col_pin_oe_out, indicator_one_oe_out, indicator_two_oe_out}), 0);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    check(32'({phy_config_straps_out, mgmt_addr_straps_out, reduced_iface_select_out, irq_pin_function_select_out,
      regulator_enable_out, straps_valid_out}), 32'({m, a, rm, is, !rg, 1'b1}));
    av(1'b0, ADDR_STATUS, 32'h0, q);
    check(q, {19'h0, 3'h0, 1'b1, rg, is, rm, a, m});
    av(1'b0, ADDR_WAKE_CTRL, 32'h0, q);
    check(q, {23'h0, 1'b0, m[1], m[0], 2'b00, INDICATOR_TWO_SEL_RESET, INDICATOR_ONE_SEL_RESET});
    $display("Test reset done");
  endtask

  initial
  begin
    int k;
    do_reset(3'h5, 3'h6, 1'b0, 1'b1, 1'b1);
    for (int s = 0; s < 2; s++)
    begin
      av(1'b1, ADDR_WAKE_CTRL, 32'(s << CTL_SPD100) | 32'h4, q);
      k = 0;
      wl(1'b0, k);
      wl(1'b1, k);
      k = 0;
      wl(1'b0, k);
      wl(1'b1, k);
      check(32'(k), (s == 1) ? 32'h2 : 32'h10);
    end
    rx_dv_in <= 1'b1;
    rx_data_in <= 4'hA;
    rx_err_in <= 1'b1;
    col_in <= 1'b1;
    crs_in <= 1'b1;
    wt(2);
    check(32'({rxdv_pin_out, rxd_pin_out, rxer_pin_out, col_pin_out, crs_pin_out}), 32'hD7);
    wt(2);
    check(32'(last_nib), 32'hA);
    check(32'(nibs != 16'h0), 32'h1);
    {rx_dv_in, rx_err_in, col_in, crs_in} <= 4'h0;
    wt(2);
    check(32'({rxdv_pin_out, rxer_pin_out, col_pin_out, crs_pin_out}), 32'h0);
    av(1'b1, ADDR_WAKE_CTRL, 32'h54, q);
    rx_lpi_in <= 1'b1;
    wt(2);
    check(32'(rxer_pin_out), 32'h1);
    rx_dv_in <= 1'b1;
    wt(2);
    check(32'(rxer_pin_out), 32'h0);
    av(1'b1, ADDR_WAKE_CTRL, 32'h64, q);
    rx_sym_msb_in <= 1'b1;
    wt(2);
    check(32'(rxer_pin_out), 32'h1);
    {rx_sym_msb_in, rx_err_in, rx_dv_in, rx_lpi_in} <= 4'h2;
    wt(2);
    check(32'(rxer_pin_out), 32'h0);
    $display("Test mii done");
    av(1'b1, ADDR_WAKE_CTRL, 32'h44, q);
    irq_in <= 1'b1;
    link_act_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check(32'({irq_pin_oe_out, irq_pin_out, indicator_one_out, indicator_two_out}), 32'hB);
    av(1'b1, ADDR_WAKE_CTRL, 32'h4E, q);
    pme_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check(32'({irq_pin_oe_out, indicator_one_out, indicator_two_out, indicator_one_oe_out,
      indicator_two_oe_out}), 32'h3);
    av(1'b1, ADDR_WAKE_CTRL, 32'h4B, q);
    irq_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check(32'({indicator_one_out, indicator_two_out}), 32'h1);
    av(1'b1, 4'hC, 32'hFF, q);
    av(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0);
    av(1'b0, ADDR_WAKE_CTRL, 32'h0, q);
    check(q, 32'h4B);
    check(32'(phy_config_straps_out), 32'h5);
    $display("Test indicators done");
    mdio_drive_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    check(32'({mdio_oe_out, mdio_out, mdio_sample_out}), 32'h4);
    mdio_drive_in <= 1'b0;
    start <= 1'b1;
    repeat (80) @(posedge clk_in);
    check(32'(rises), 32'h8);
    $display("Test management done");
    {start, pme_in, rx_dv_in} <= 3'b000;
    do_reset(3'h0, 3'h3, 1'b1, 1'b0, 1'b0);
    check(32'(rxclk_pin_oe_out), 32'h0);
    {crs_in, rx_dv_in} <= 2'b11;
    rx_data_in <= 4'h1;
    wt(2);
    check(32'({col_pin_out, crs_pin_out, rxd_pin_out}), 32'h20);
    for (int i = 0; i < 3; i++)
    begin
      wt(1);
      check(32'(rxd_pin_out), 32'h0);
    end
    rx_data_in <= 4'h3;
    wt(1);
    rx_data_in <= 4'h2;
    wt(1);
    check(32'(rxd_pin_out), 32'h2);
    tx_en_in <= 1'b1;
    wt(1);
    check(32'(rxd_pin_out), 32'h0);
    tx_en_in <= 1'b0;
    av(1'b1, ADDR_WAKE_CTRL, 32'h104, q);
    pme_in <= 1'b1;
    wt(2);
    check(32'(rxd_pin_out), 32'h2);
    pme_in <= 1'b0;
    wt(2);
    check(32'(rxd_pin_out), 32'h6);
    {irq_in, txer_drv} <= 2'b11;
    repeat (4) @(posedge clk_in);
    check(32'({tx_err_out, irq_pin_oe_out}), 32'h2);
    $display("Test rmii done");
    conclude();
  end
endmodule // pmr_rx_pins_tb_top
